// ==== hdl/lin_uart.sv ====
// LIN extensions of an asynchronous serial port: auto-baud, wake, break.
// Assumes receive_line and control inputs are synchronous to clk.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Auto-baud times a received 0x55 sync character on the receive line.
// [R2] Enabling auto-baud starts calibration; receiver held idle throughout.
// [R3] Counting starts at first rise after start bit, stops at fifth rise.
// [R4] At end: count kept in divider, enable cleared, receive flag set.
// [R5] Divider is one 16-bit counter during calibration at base clock/8.
// [R6] Calibration clock is oscillator /32, /128 or /512 by the two selects.
// [R7] Counter starts from one; software subtracts one afterwards.
// [R8] Software checks high divider byte zero for 8-bit modes.
// [R9] With wake also set, rate detection uses the byte after the break.
// [R10] Overflow flag set when the counter wraps before the fifth rise.
// [R11] After overflow keep counting to fifth rise, then flag and clear enable.
// [R12] Overflow flag clearable by software only once auto-baud enable is clear.
// [R13] Wake mode blocks reception; falling receive edge is the wake event.
// [R14] Receive flag rises with the wake event; cleared by data read.
// [R15] Wake enable clears on the rising edge ending the break.
// [R16] Nonzero character: low time to first rise is the wake event.
// [R17] Remote sends at least ten zero bit times as wake character.
// [R18] Transmitted break is start, twelve zeros, stop.
// [R19] With break request and transmit enable, a data write starts zeros.
// [R20] Break request cleared after stop bit; buffered byte follows.
// [R21] Shifter-empty status tracks break exactly as a normal character.
// [R22] Received break shows receive flag, framing error and zero data.
module lin_uart #(
	parameter int unsigned CLK_MHZ = lin_uart_pkg::CLK_MHZ
) (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic                    ce,
	input  wire logic                    receive_line,
	output logic                         tx_line,
	input  wire lin_uart_pkg::rate_cfg_t rate_cfg,
	input  wire logic                    div_write,
	input  wire logic [15:0]             div_wdata,
	input  wire logic                    autobaud_enable_set,
	input  wire logic                    autobaud_enable_clr,
	input  wire logic                    overflow_clr,
	input  wire logic                    wake_enable_set,
	input  wire logic                    wake_enable_clr,
	input  wire logic                    send_break_set,
	input  wire logic                    transmit_enable,
	input  wire logic                    receive_enable,
	input  wire logic                    tx_write,
	input  wire logic [7:0]              tx_data_reg,
	input  wire logic                    rx_read,
	input  wire logic                    err_clr,
	output logic [7:0]                   baud_div_high,
	output logic [7:0]                   baud_div_low,
	output logic                         autobaud_enable,
	output logic                         autobaud_overflow_flag,
	output logic                         wake_on_break_enable,
	output logic                         send_break_request,
	output logic                         tx_shifter_empty,
	output logic                         tx_interrupt_flag,
	output lin_uart_pkg::rx_status_t     rx_status,
	output logic                         receiver_idle_status
);
	lin_uart_pkg::rx_state_t rx_state;
	lin_uart_pkg::ab_state_t ab_state;
	logic [15:0] divider;
	logic        rx_prev;
	logic        rise;
	logic        fall;
	logic [5:0]  base_pre;
	logic [2:0]  ab_sub;
	logic [9:0]  ab_pre;
	logic [9:0]  ab_pre_last;
	logic [2:0]  rise_cnt;
	logic        ab_done;
	logic        ab_hit;
	logic        bit_tick;
	logic        os_tick;
	logic [2:0]  rx_bit;
	logic [7:0]  rx_shift;
	logic        break_done;
	logic        wake_event;
	logic        wake_end;

	initial
	begin
		if (CLK_MHZ == 0)
			$error("clock rate must be nonzero");
	end

	assign rise = receive_line & ~rx_prev;
	assign fall = ~receive_line & rx_prev;
	assign baud_div_high = divider[15:8];
	assign baud_div_low  = divider[7:0];
	assign receiver_idle_status = (rx_state == lin_uart_pkg::RX_IDLE);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rx_prev <= 1'b1;
		else if (ce)
			rx_prev <= receive_line;
	end

	// Base clock prescale by rate selects
	always_comb
	begin
		if (rate_cfg.wide_divider_select && rate_cfg.high_speed_select)
			base_pre = 6'(lin_uart_pkg::BASE_DIV_BOTH / lin_uart_pkg::OVERSAMPLE * 0);
		else if (rate_cfg.wide_divider_select || rate_cfg.high_speed_select)
			base_pre = 6'(lin_uart_pkg::BASE_DIV_ONE / lin_uart_pkg::OVERSAMPLE - 1);
		else
			base_pre = 6'(lin_uart_pkg::BASE_DIV_NONE / lin_uart_pkg::OVERSAMPLE - 1);
	end

	// [R6] Calibration clock divide
	always_comb
	begin
		if (rate_cfg.wide_divider_select && rate_cfg.high_speed_select)
			ab_pre_last = 10'(lin_uart_pkg::ABD_DIV_BOTH - 1);
		else if (rate_cfg.wide_divider_select || rate_cfg.high_speed_select)
			ab_pre_last = 10'(lin_uart_pkg::ABD_DIV_ONE - 1);
		else
			ab_pre_last = 10'(lin_uart_pkg::ABD_DIV_NONE - 1);
	end

	// Oversample tick: eight per bit time
	lin_tick_gen #(
		.PRE_W (6)
	) u_os_tick (
		.clk      (clk),
		.rst_b    (rst_b),
		.ce       (ce),
		.run      (ab_state == lin_uart_pkg::AB_OFF),
		.prescale (base_pre),
		.period   (divider),
		.tick     (os_tick)
	);

	// Bit tick for transmit: every eighth oversample
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ab_sub   <= 3'h0;
			bit_tick <= 1'b0;
		end
		else if (ce)
		begin
			bit_tick <= 1'b0;
			if (os_tick)
			begin
				ab_sub <= ab_sub + 3'h1;
				if (ab_sub == 3'h7)
					bit_tick <= 1'b1;
			end
		end
	end

	assign ab_hit = (ab_pre == ab_pre_last);

	// [R1] Auto-baud: line times counter
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ab_state <= lin_uart_pkg::AB_OFF;
			ab_pre   <= 10'h000;
			rise_cnt <= 3'h0;
			ab_done  <= 1'b0;
		end
		else if (ce)
		begin
			ab_done <= 1'b0;
			case (ab_state)
				lin_uart_pkg::AB_OFF:
				begin
					// [R9] Wait out the break
					if (autobaud_enable && !wake_on_break_enable && fall)
						ab_state <= lin_uart_pkg::AB_START;
				end
				lin_uart_pkg::AB_START:
				begin
					// [R3] First rise after start
					if (!autobaud_enable)
						ab_state <= lin_uart_pkg::AB_OFF;
					else if (rise)
					begin
						ab_pre   <= 10'h000;
						rise_cnt <= 3'h1;
						ab_state <= lin_uart_pkg::AB_COUNT;
					end
				end
				lin_uart_pkg::AB_COUNT:
				begin
					ab_pre <= ab_hit ? 10'h000 : ab_pre + 10'h001;
					if (!autobaud_enable)
						ab_state <= lin_uart_pkg::AB_OFF;
					else if (rise)
					begin
						rise_cnt <= rise_cnt + 3'h1;
						// [R3] Stop at fifth rise
						if (rise_cnt == 3'(lin_uart_pkg::SYNC_RISES - 1))
						begin
							ab_done  <= 1'b1;
							ab_state <= lin_uart_pkg::AB_DONE;
						end
					end
				end
				lin_uart_pkg::AB_DONE:
					ab_state <= lin_uart_pkg::AB_OFF;
				default:
					ab_state <= lin_uart_pkg::AB_OFF;
			endcase
		end
	end

	// [R5] One 16-bit counter, base/8
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			divider <= lin_uart_pkg::DIV_RESET;
		else if (ce)
		begin
			if (ab_state == lin_uart_pkg::AB_START && rise && autobaud_enable)
				// [R7] Start from one
				divider <= lin_uart_pkg::ABD_START;
			else if (ab_state == lin_uart_pkg::AB_COUNT && ab_hit)
				// [R11] Wraps and keeps counting
				divider <= divider + 16'h0001;
			else if (div_write && !autobaud_enable && ab_state == lin_uart_pkg::AB_OFF)
				divider <= div_wdata;
		end
	end

	// [R10] Overflow on wrap
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			autobaud_overflow_flag <= 1'b0;
		else if (ce)
		begin
			if (ab_state == lin_uart_pkg::AB_COUNT && ab_hit && divider == 16'hFFFF)
				autobaud_overflow_flag <= 1'b1;
			// [R12] Clear only with enable low
			else if (overflow_clr && !autobaud_enable)
				autobaud_overflow_flag <= 1'b0;
		end
	end

	// [R4] Enable self-clears on completion
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			autobaud_enable <= 1'b0;
		else if (ce)
		begin
			if (autobaud_enable_set)
				autobaud_enable <= 1'b1;
			else if (ab_done || autobaud_enable_clr)
				autobaud_enable <= 1'b0;
		end
	end

	// [R13] Falling edge wakes
	assign wake_event = wake_on_break_enable && fall;
	// [R15] Rising edge ends break
	assign wake_end = wake_on_break_enable && rise;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			wake_on_break_enable <= 1'b0;
		else if (ce)
		begin
			// [R16] First rise ends wake
			if (wake_end)
				wake_on_break_enable <= 1'b0;
			else if (wake_enable_set)
				wake_on_break_enable <= 1'b1;
			else if (wake_enable_clr)
				wake_on_break_enable <= 1'b0;
		end
	end

	// [R20] Hardware clears break request
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			send_break_request <= 1'b0;
		else if (ce)
		begin
			if (break_done)
				send_break_request <= 1'b0;
			else if (send_break_set)
				send_break_request <= 1'b1;
		end
	end

	// Receiver: mid-bit sampling
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_state  <= lin_uart_pkg::RX_IDLE;
			rx_bit    <= 3'h0;
			rx_shift  <= lin_uart_pkg::BYTE_RESET;
			rx_status <= '0;
		end
		else if (ce)
		begin
			if (rx_read)
				rx_status.rx_interrupt_flag <= 1'b0;
			if (err_clr)
				rx_status.overrun_flag <= 1'b0;
			// [R14] Flag with wake event
			if (wake_event)
				rx_status.rx_interrupt_flag <= 1'b1;
			// [R4] Flag at calibration end
			if (ab_done)
				rx_status.rx_interrupt_flag <= 1'b1;
			case (rx_state)
				lin_uart_pkg::RX_IDLE:
				begin
					// [R2] Held idle while calibrating
					if (receive_enable && !autobaud_enable && !wake_on_break_enable && fall)
						rx_state <= lin_uart_pkg::RX_START;
				end
				lin_uart_pkg::RX_START:
				begin
					if (os_tick && ab_sub == 3'h3)
					begin
						rx_bit   <= 3'h0;
						rx_state <= receive_line ? lin_uart_pkg::RX_IDLE :
							lin_uart_pkg::RX_HOLD;
					end
				end
				lin_uart_pkg::RX_HOLD:
				begin
					if (bit_tick)
						rx_state <= lin_uart_pkg::RX_DATA;
				end
				lin_uart_pkg::RX_DATA:
				begin
					if (os_tick && ab_sub == 3'h3)
					begin
						rx_shift <= {receive_line, rx_shift[7:1]};
						rx_bit   <= rx_bit + 3'h1;
						if (rx_bit == 3'(lin_uart_pkg::DATA_BITS - 1))
							rx_state <= lin_uart_pkg::RX_STOP;
					end
				end
				lin_uart_pkg::RX_STOP:
				begin
					if (os_tick && ab_sub == 3'h3 && rx_bit == 3'h0)
					begin
						if (rx_status.rx_interrupt_flag && !rx_read)
							rx_status.overrun_flag <= 1'b1;
						else
						begin
							rx_status.rx_data_reg        <= rx_shift;
							// [R22] Break: stop bit low
							rx_status.framing_error_flag <= ~receive_line;
							rx_status.rx_interrupt_flag  <= 1'b1;
						end
						rx_state <= lin_uart_pkg::RX_IDLE;
					end
					else if (os_tick && ab_sub == 3'h3)
						rx_bit <= 3'h0;
				end
				default:
					rx_state <= lin_uart_pkg::RX_IDLE;
			endcase
			// [R2] [R13] Forced idle while blocked
			if (autobaud_enable || autobaud_enable_set ||
				wake_on_break_enable || wake_enable_set)
				rx_state <= lin_uart_pkg::RX_IDLE;
		end
	end

	lin_tx_shifter u_tx (
		.clk                (clk),
		.rst_b              (rst_b),
		.ce                 (ce),
		.tick               (bit_tick),
		.transmit_enable    (transmit_enable),
		.send_break_request (send_break_request),
		.tx_write           (tx_write),
		.tx_data_reg        (tx_data_reg),
		.tx_line            (tx_line),
		.tx_shifter_empty   (tx_shifter_empty),
		.tx_interrupt_flag  (tx_interrupt_flag),
		.break_done         (break_done)
	);
endmodule // lin_uart

// ==== hdl/lin_uart_pkg.sv ====
// Package for the LIN-extended asynchronous serial port.
// Assumes a single 100 MHz system clock feeds every block.
package lin_uart_pkg;

	localparam int unsigned CLK_MHZ        = 100;
	localparam int unsigned ABD_DIV_BOTH   = 32;
	localparam int unsigned ABD_DIV_ONE    = 128;
	localparam int unsigned ABD_DIV_NONE   = 512;
	localparam int unsigned BASE_DIV_BOTH  = 4;
	localparam int unsigned BASE_DIV_ONE   = 16;
	localparam int unsigned BASE_DIV_NONE  = 64;
	localparam int unsigned SYNC_RISES     = 5;
	localparam int unsigned BREAK_ZEROS    = 12;
	localparam int unsigned DATA_BITS      = 8;
	localparam int unsigned OVERSAMPLE     = 16;
	localparam logic [15:0] ABD_START      = 16'h0001;
	localparam logic [15:0] DIV_RESET      = 16'h0000;
	localparam logic [7:0]  BYTE_RESET     = 8'h00;

	typedef struct packed {
		logic wide_divider_select;
		logic high_speed_select;
	} rate_cfg_t;

	typedef struct packed {
		logic       rx_interrupt_flag;
		logic       framing_error_flag;
		logic       overrun_flag;
		logic [7:0] rx_data_reg;
	} rx_status_t;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA  = 5'b00100,
		RX_STOP  = 5'b01000,
		RX_HOLD  = 5'b10000
	} rx_state_t;

	typedef enum logic [3:0] {
		TX_IDLE  = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA  = 4'b0100,
		TX_STOP  = 4'b1000
	} tx_state_t;

	typedef enum logic [3:0] {
		AB_OFF   = 4'b0001,
		AB_START = 4'b0010,
		AB_COUNT = 4'b0100,
		AB_DONE  = 4'b1000
	} ab_state_t;

endpackage

// ==== hdl/lin_tick_gen.sv ====
// Baud tick generator, one pulse per programmed period of the base clock.
// Assumes divider value and base prescale are stable while running.
`timescale 1ns/1ps
module lin_tick_gen #(
	parameter int unsigned PRE_W = 6
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              ce,
	input  wire logic              run,
	input  wire logic [PRE_W-1:0]  prescale,
	input  wire logic [15:0]       period,
	output logic                   tick
);
	logic [PRE_W-1:0] pre_cnt;
	logic [15:0]      per_cnt;
	logic             pre_hit;

	initial
	begin
		if (PRE_W < 1)
			$error("prescale width too small");
	end

	assign pre_hit = (pre_cnt == prescale);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pre_cnt <= '0;
			per_cnt <= '0;
			tick    <= 1'b0;
		end
		else if (ce)
		begin
			tick <= 1'b0;
			if (!run)
			begin
				pre_cnt <= '0;
				per_cnt <= '0;
			end
			else if (pre_hit)
			begin
				pre_cnt <= '0;
				if (per_cnt >= period)
				begin
					per_cnt <= '0;
					tick    <= 1'b1;
				end
				else
					per_cnt <= per_cnt + 16'h0001;
			end
			else
				pre_cnt <= pre_cnt + 1'b1;
		end
	end
endmodule // lin_tick_gen

// ==== hdl/lin_tx_shifter.sv ====
// Transmit shifter with one-byte holding buffer and break generation.
// Assumes tick is one pulse per bit time.
`timescale 1ns/1ps
module lin_tx_shifter (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       ce,
	input  wire logic       tick,
	input  wire logic       transmit_enable,
	input  wire logic       send_break_request,
	input  wire logic       tx_write,
	input  wire logic [7:0] tx_data_reg,
	output logic            tx_line,
	output logic            tx_shifter_empty,
	output logic            tx_interrupt_flag,
	output logic            break_done
);
	lin_uart_pkg::tx_state_t state;
	logic [7:0] hold;
	logic       hold_full;
	logic [7:0] shift;
	logic [3:0] bit_cnt;
	logic [3:0] bit_last;
	logic       in_break;
	logic       load;

	assign tx_interrupt_flag = ~hold_full;
	// Hold off while break request clears
	assign load = (state == lin_uart_pkg::TX_IDLE) && hold_full && transmit_enable &&
		!break_done;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hold_full <= 1'b0;
		else if (ce)
		begin
			if (tx_write && transmit_enable)
				hold_full <= 1'b1;
			else if (load)
				hold_full <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hold <= lin_uart_pkg::BYTE_RESET;
		else if (ce && tx_write && transmit_enable)
			hold <= tx_data_reg;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state            <= lin_uart_pkg::TX_IDLE;
			shift            <= lin_uart_pkg::BYTE_RESET;
			bit_cnt          <= 4'h0;
			bit_last         <= 4'h0;
			in_break         <= 1'b0;
			tx_line          <= 1'b1;
			tx_shifter_empty <= 1'b1;
			break_done       <= 1'b0;
		end
		else if (ce)
		begin
			break_done <= 1'b0;
			case (state)
				lin_uart_pkg::TX_IDLE:
				begin
					tx_line <= 1'b1;
					if (load)
					begin
						// [R19] Break ignores data
						shift            <= send_break_request ? 8'h00 : hold;
						in_break         <= send_break_request;
						// [R18] Twelve zero bits
						bit_last         <= send_break_request ?
							4'(lin_uart_pkg::BREAK_ZEROS - 1) :
							4'(lin_uart_pkg::DATA_BITS - 1);
						// [R21] Busy as normal
						tx_shifter_empty <= 1'b0;
						state            <= lin_uart_pkg::TX_START;
					end
				end
				lin_uart_pkg::TX_START:
				begin
					if (tick)
					begin
						tx_line <= 1'b0;
						bit_cnt <= 4'h0;
						state   <= lin_uart_pkg::TX_DATA;
					end
				end
				lin_uart_pkg::TX_DATA:
				begin
					if (tick)
					begin
						tx_line <= shift[0];
						shift   <= {1'b0, shift[7:1]};
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == bit_last)
							state <= lin_uart_pkg::TX_STOP;
					end
				end
				lin_uart_pkg::TX_STOP:
				begin
					if (tick)
					begin
						tx_line <= 1'b1;
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt != bit_last + 4'h1)
						begin
							// [R20] Clear after stop
							break_done       <= in_break;
							in_break         <= 1'b0;
							tx_shifter_empty <= 1'b1;
							state            <= lin_uart_pkg::TX_IDLE;
						end
					end
				end
				default:
					state <= lin_uart_pkg::TX_IDLE;
			endcase
		end
	end
endmodule // lin_tx_shifter

// ==== verification/lin_remote_node.sv ====
// Remote serial node: drives the receive line and times the transmit line.
// Assumes callers enter the send tasks just after a falling clock edge.
`timescale 1ns/1ps
module lin_remote_node (
	input  wire logic clk,
	input  wire logic tx_line,
	output logic      receive_line
);
	initial receive_line = 1'b1;

	task automatic hold(input logic v, input int cycles);
		receive_line = v;
		repeat (cycles) @(negedge clk);
	endtask

	task automatic send_byte(input logic [7:0] b, input int bt);
		hold(1'b0, bt);
		for (int i = 0; i < 8; i++)
			hold(b[i], bt);
		hold(1'b1, bt);
	endtask

	task automatic send_break(input int nbits, input int bt);
		hold(1'b0, nbits * bt);
		hold(1'b1, bt);
	endtask

	task automatic low_run(output int n);
		n = 0;
		while (tx_line)
			@(posedge clk);
		while (!tx_line)
		begin
			n++;
			@(posedge clk);
		end
	endtask

	// Sample each data bit near its middle
	task automatic catch_byte(input int bt, output logic [7:0] b);
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			b[i] = tx_line;
			repeat (bt) @(posedge clk);
		end
	endtask
endmodule // lin_remote_node

// ==== verification/lin_uart_monitor.sv ====
// Checker for the serial port extensions: auto-baud, wake and break.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module lin_uart_monitor (
	input wire logic                     clk,
	input wire logic                     rst_b,
	input wire logic                     ce,
	input wire logic                     receive_line,
	input wire logic                     tx_line,
	input wire logic                     div_write,
	input wire logic                     autobaud_enable_clr,
	input wire logic [7:0]               baud_div_high,
	input wire logic [7:0]               baud_div_low,
	input wire logic                     autobaud_enable,
	input wire logic                     autobaud_overflow_flag,
	input wire logic                     wake_on_break_enable,
	input wire logic                     send_break_request,
	input wire logic                     tx_shifter_empty,
	input wire lin_uart_pkg::rx_status_t rx_status,
	input wire logic                     receiver_idle_status
);
	default clocking mon_clk @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence cal_end;
		$fell(autobaud_enable) && !$past(autobaud_enable_clr);
	endsequence
	sequence break_end;
		$fell(send_break_request);
	endsequence

	abd_done_a: assert property (cal_end |-> rx_status.rx_interrupt_flag)
		else $error("calibration ended without receive flag");
	ovf_hold_a: assert property (
		autobaud_enable && autobaud_overflow_flag |=> autobaud_overflow_flag)
		else $error("overflow flag dropped during calibration");
	ovf_cause_a: assert property ($rose(autobaud_overflow_flag) |-> $past(autobaud_enable))
		else $error("overflow flag set outside calibration");
	ovf_keep_a: assert property ($rose(autobaud_overflow_flag) |-> autobaud_enable)
		else $error("calibration stopped at counter wrap");
	rx_blocked_a: assert property (
		autobaud_enable || wake_on_break_enable |-> receiver_idle_status)
		else $error("receiver active while calibrating or waiting for wake");
	wake_flag_a: assert property (
		ce && wake_on_break_enable && $fell(receive_line)
		|-> ##[1:2] rx_status.rx_interrupt_flag)
		else $error("no receive flag on wake event");
	wake_end_a: assert property (
		ce && wake_on_break_enable && $rose(receive_line) |-> ##[1:2] !wake_on_break_enable)
		else $error("wake enable not cleared by rising edge");
	brk_stop_a: assert property (break_end |-> $past(tx_line))
		else $error("break request cleared before stop bit");
	tx_busy_a: assert property (!tx_line |-> !tx_shifter_empty)
		else $error("shifter shown empty while line driven low");
	div_hold_a: assert property (
		!autobaud_enable && !$past(autobaud_enable) && !$past(div_write)
		|-> $stable({baud_div_high, baud_div_low}))
		else $error("divider changed without write or calibration");
endmodule // lin_uart_monitor

bind lin_uart lin_uart_monitor u_monitor (
	.clk(clk), .rst_b(rst_b), .ce(ce), .receive_line(receive_line), .tx_line(tx_line),
	.div_write(div_write), .autobaud_enable_clr(autobaud_enable_clr),
	.baud_div_high(baud_div_high), .baud_div_low(baud_div_low),
	.autobaud_enable(autobaud_enable), .autobaud_overflow_flag(autobaud_overflow_flag),
	.wake_on_break_enable(wake_on_break_enable), .send_break_request(send_break_request),
	.tx_shifter_empty(tx_shifter_empty), .rx_status(rx_status),
	.receiver_idle_status(receiver_idle_status)
);

// ==== verification/test_lin_uart.sv ====
// Self-checking bench for the serial port extensions.
// Assumes the remote node model and the checker are compiled alongside.
`timescale 1ns/1ps
module test_lin_uart;
	localparam int         BT     = 256;
	localparam logic [8:0] AB_SET = 9'h001;
	localparam logic [8:0] AB_CLR = 9'h002;
	localparam logic [8:0] OV_CLR = 9'h004;
	localparam logic [8:0] WK_SET = 9'h008;
	localparam logic [8:0] WK_CLR = 9'h010;
	localparam logic [8:0] BK_SET = 9'h020;
	localparam logic [8:0] RX_RD  = 9'h040;
	localparam logic [8:0] DIV_WR = 9'h080;
	localparam logic [8:0] TX_WR  = 9'h100;
	logic                     clk = 1'b0;
	logic                     rst_b = 1'b0;
	logic [8:0]               pulses = 9'h000;
	logic                     transmit_enable = 1'b0;
	logic                     receive_enable = 1'b1;
	logic [15:0]              div_wdata = 16'h0000;
	logic [7:0]               tx_data_reg = 8'h00;
	lin_uart_pkg::rate_cfg_t  rate_cfg = 2'b11;
	logic                     receive_line, tx_line, autobaud_enable, autobaud_overflow_flag;
	logic                     wake_on_break_enable, send_break_request, tx_shifter_empty;
	logic                     tx_interrupt_flag, receiver_idle_status;
	logic [7:0]               baud_div_high, baud_div_low, got;
	lin_uart_pkg::rx_status_t rx_status;
	int                       err_count = 0;
	int                       compares = 0;
	int                       lo_brk, lo_st;

	always #5 clk = ~clk;

	lin_uart u_dut (
		.clk(clk), .rst_b(rst_b), .ce(1'b1), .receive_line(receive_line), .tx_line(tx_line),
		.rate_cfg(rate_cfg), .div_write(pulses[7]), .div_wdata(div_wdata),
		.autobaud_enable_set(pulses[0]), .autobaud_enable_clr(pulses[1]),
		.overflow_clr(pulses[2]), .wake_enable_set(pulses[3]), .wake_enable_clr(pulses[4]),
		.send_break_set(pulses[5]), .transmit_enable(transmit_enable),
		.receive_enable(receive_enable), .tx_write(pulses[8]), .tx_data_reg(tx_data_reg),
		.rx_read(pulses[6]), .err_clr(1'b0), .baud_div_high(baud_div_high),
		.baud_div_low(baud_div_low), .autobaud_enable(autobaud_enable),
		.autobaud_overflow_flag(autobaud_overflow_flag),
		.wake_on_break_enable(wake_on_break_enable), .send_break_request(send_break_request),
		.tx_shifter_empty(tx_shifter_empty), .tx_interrupt_flag(tx_interrupt_flag),
		.rx_status(rx_status), .receiver_idle_status(receiver_idle_status)
	);

	lin_remote_node u_node (.clk(clk), .tx_line(tx_line), .receive_line(receive_line));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic pulse(input logic [8:0] m);
		pulses = m;
		@(negedge clk);
		pulses = 9'h000;
		@(negedge clk);
	endtask

	// Sync count spans eight bit times, one count of slack
	task automatic div_near(input int c);
		logic [15:0] v;
		int          dv;
		int          e;
		v = {baud_div_high, baud_div_low};
		dv = (c == 3) ? lin_uart_pkg::ABD_DIV_BOTH : lin_uart_pkg::ABD_DIV_ONE;
		if (c == 0)
			dv = lin_uart_pkg::ABD_DIV_NONE;
		e = 8 * BT / dv + 1;
		check("baud_div_near", {15'h0000, v >= e - 1 && v <= e + 1}, 16'h0001);
	endtask

	task automatic close_out();
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		check("reset_state", {8'h00, tx_line, tx_shifter_empty, tx_interrupt_flag,
			receiver_idle_status, autobaud_enable, wake_on_break_enable,
			send_break_request, rx_status.rx_interrupt_flag}, 16'h00F0);
		for (int c = 0; c < 4; c++)
		begin
			rate_cfg = 2'(c);
			pulse(AB_SET);
			u_node.send_byte(8'h55, BT);
			repeat (4) @(negedge clk);
			check("ab_end", {14'h0000, autobaud_enable, rx_status.rx_interrupt_flag}, 16'h0001);
			div_near(c);
			check("div_high", {8'h00, baud_div_high}, 16'h0000);
			pulse(RX_RD);
			check("rx_flag", {15'h0000, rx_status.rx_interrupt_flag}, 16'h0000);
		end
		rate_cfg = 2'b11;
		pulse(AB_SET | WK_SET);
		u_node.hold(1'b0, 8);
		check("wake_evt", {14'h0000, wake_on_break_enable, rx_status.rx_interrupt_flag}, 16'h0003);
		u_node.hold(1'b0, 13 * BT - 8);
		u_node.hold(1'b1, BT);
		check("wake_end", {14'h0000, wake_on_break_enable, autobaud_enable}, 16'h0001);
		pulse(RX_RD);
		u_node.send_byte(8'h55, BT);
		repeat (4) @(negedge clk);
		check("ab_after", {14'h0000, autobaud_enable, rx_status.rx_interrupt_flag}, 16'h0001);
		div_near(3);
		pulse(RX_RD);
		div_wdata = 16'h000F;
		pulse(DIV_WR);
		pulse(AB_SET);
		div_wdata = 16'h1234;
		pulse(DIV_WR);
		check("div_lock", {baud_div_high, baud_div_low}, 16'h000F);
		pulse(AB_CLR | WK_SET);
		pulse(OV_CLR | WK_CLR);
		check("abort", {13'h0000, autobaud_enable, autobaud_overflow_flag,
			wake_on_break_enable}, 16'h0000);
		u_node.send_break(40, BT);
		repeat (8) @(negedge clk);
		check("rx_break", {5'h00, rx_status.rx_interrupt_flag, rx_status.framing_error_flag,
			rx_status.overrun_flag, rx_status.rx_data_reg}, 16'h0600);
		pulse(RX_RD);
		transmit_enable = 1'b1;
		fork
			begin
				u_node.low_run(lo_brk);
				u_node.low_run(lo_st);
				u_node.catch_byte(lo_st, got);
			end
			begin
				pulse(BK_SET);
				tx_data_reg = 8'hA5;
				pulse(TX_WR);
				check("tx_busy", {15'h0000, tx_shifter_empty}, 16'h0000);
				tx_data_reg = 8'h55;
				pulse(TX_WR);
			end
		join
		check("brk_len", 16'((lo_brk + lo_st / 2) / lo_st), 16'h000D);
		check("sync_byte", {8'h00, got}, 16'h0055);
		check("brk_clr", {15'h0000, send_break_request}, 16'h0000);
		repeat (lo_st * 2) @(negedge clk);
		check("tx_idle", {15'h0000, tx_shifter_empty}, 16'h0001);
		close_out();
	end

	// Whole run is near 31k cycles; cut off at 100k
	initial
	begin
		#1000000;
		err_count++;
		close_out();
	end
endmodule // test_lin_uart
